// [logic/cpusup_regs.svh]
/*
 Timing counts, selector encodings and input bit positions of the supervisor.
 Assumes a 125 MHz system clock and a 1 ms internal slow tick.
*/
`ifndef CPUSUP_REGS_SVH
`define CPUSUP_REGS_SVH

// ************************************************************
// Clock and slow tick
// ************************************************************
`define CPUSUP_CLK_MHZ 125
`define CPUSUP_TICK_US 1000
`define CPUSUP_TICK_CYC (`CPUSUP_TICK_US * `CPUSUP_CLK_MHZ)
`define CPUSUP_MS_TICKS(ms) (((ms) * 1000) / `CPUSUP_TICK_US)
`define CPUSUP_TICK_W 17
`define CPUSUP_CNT_W 12

// ************************************************************
// Power-up reset times, watchdog intervals, debounce (ms)
// ************************************************************
`define CPUSUP_PUP0_MS 50
`define CPUSUP_PUP1_MS 200
`define CPUSUP_PUP2_MS 400
`define CPUSUP_PUP3_MS 800
`define CPUSUP_WD0_MS 25
`define CPUSUP_WD1_MS 200
`define CPUSUP_WD2_MS 1400
`define CPUSUP_DEB_MS 5
`define CPUSUP_DEB_W 4

// ************************************************************
// Selector encodings and values after reset
// ************************************************************
`define CPUSUP_SEL_0 2'h0
`define CPUSUP_SEL_1 2'h1
`define CPUSUP_SEL_2 2'h2
`define CPUSUP_WD_OFF 2'h3
`define CPUSUP_WD_SEL_RST 2'h0
`define CPUSUP_PUP_SEL_RST 2'h0

// ************************************************************
// Positions in the synchronised input vector
// ************************************************************
`define CPUSUP_IN_PRI 0
`define CPUSUP_IN_SEC 1
`define CPUSUP_IN_ABOVE 2
`define CPUSUP_IN_BELOW 3
`define CPUSUP_IN_MR 4
`define CPUSUP_IN_WP 5
`define CPUSUP_IN_W 6

`endif

// [logic/cpusup_pkg.sv]
/*
 Types shared by the supervisor modules.
 Assumes nothing of its surroundings.
*/
package cpusup_pkg;

   // ************************************************************
   // System reset sequencer states, Gray coded along the usual path
   // ************************************************************
   typedef enum logic [1:0] {
      cpusup_rst_hold = 2'h0,
      cpusup_rst_count = 2'h1,
      cpusup_rst_run = 2'h3
   } cpusup_rst_state_t;

endpackage

// [logic/cpusup_sync.sv]
/*
 Two flip-flop synchroniser for a vector of unrelated levels.
 Assumes the destination clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module cpusup_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else if (en) begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

// [logic/cpusup_bus_watch.sv]
/*
 Two-wire bus activity watcher on the link clock.
 Assumes link_clk oversamples SDA and SCL and runs freely; rst_n and ce come from
 the system clock domain and are synchronised here.
*/
`timescale 1ns/1ps
module cpusup_bus_watch (
   input wire logic link_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sda_in,
   input wire logic scl_in,
   output logic restart_tgl
);

   logic [1:0] ctl_s;
   logic [1:0] bus_s;
   logic l_rst_n;
   logic l_ce;
   logic sda_s;
   logic scl_s;
   logic sda_d_r;
   logic scl_d_r;
   logic started_r;
   logic clocked_r;
   wire start_seen;
   wire stop_seen;
   wire scl_fall;

   // ************************************************************
   // Crossing into the link domain
   // ************************************************************
   cpusup_sync #(.W(2)) u_ctl_sync (
      .clk(link_clk),
      .rst_n(1'b1),
      .en(1'b1),
      .d({ce, rst_n}),
      .q(ctl_s)
   );

   assign l_rst_n = ctl_s[0];
   assign l_ce = ctl_s[1];

   cpusup_sync #(.W(2)) u_bus_sync (
      .clk(link_clk),
      .rst_n(l_rst_n),
      .en(1'b1),
      .d({scl_in, sda_in}),
      .q(bus_s)
   );

   assign sda_s = bus_s[0];
   assign scl_s = bus_s[1];

   // ************************************************************
   // Start, clock and stop detection
   // ************************************************************
   assign start_seen = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_seen = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign scl_fall = scl_d_r && !scl_s;

   // A restart needs start, a clock low and high phase, then stop; any
   // address or direction qualifies, so full frames restart too.
   always_ff @(posedge link_clk) begin
      if (!l_rst_n) begin
         sda_d_r <= 1'b1;
         scl_d_r <= 1'b1;
         started_r <= 1'b0;
         clocked_r <= 1'b0;
         restart_tgl <= 1'b0;
      end else if (l_ce) begin
         sda_d_r <= sda_s;
         scl_d_r <= scl_s;
         if (start_seen) begin
            started_r <= 1'b1;
            clocked_r <= 1'b0;
         end else if (stop_seen) begin
            started_r <= 1'b0;
            clocked_r <= 1'b0;
            restart_tgl <= restart_tgl ^ clocked_r;
         end else if (scl_fall && started_r) begin
            clocked_r <= 1'b1;
         end
      end
   end

   stop_restart_a: assert property (
      @(posedge link_clk) disable iff (!l_rst_n)
      (l_ce && stop_seen && clocked_r) |=> (restart_tgl != $past(restart_tgl))
   ) else $error("stop after a clocked start did not restart the watchdog");

   bare_stop_a: assert property (
      @(posedge link_clk) disable iff (!l_rst_n)
      (stop_seen && !clocked_r) |=> $stable(restart_tgl)
   ) else $error("stop without a clock phase restarted the watchdog");

endmodule

// [logic/cpusup_top.sv]
/*
 Processor supervisor: system reset sequencer, manual reset debounce, supply
 fail flags, battery switch control, watchdog and bus access gating.
 Assumes comparator results arrive as asynchronous levels, SDA and SCL are sampled
 on link_clk, and cfg_wr_pulse comes from logic on clk.
*/
`timescale 1ns/1ps
`include "cpusup_regs.svh"

// What this block does
// - Watchdog restarts on start, falling clock, then stop on the bus.
// - Alarm goes active when no restart arrives within the selected period.
// - Any complete read or write to any address restarts the watchdog.
// - Two stored control bits pick the watchdog period; host may rewrite them.
// - Write protect high refuses every memory and register write.
// - Reset holds until primary supply stays good for the power-up time.
// - Bus traffic to memory is ignored while power-on reset is active.
// - Manual reset low holds reset, then the power-up time after release.
// - Primary supply below first threshold asserts reset; release uses power-up timing.
// - Secondary-fail output is driven while secondary input is below its threshold.
// - Secondary-fail releases as soon as the input is back above threshold.
// - Output supply picks primary when good, else battery with hysteresis.
// - Backup-active output is high on battery, low on primary.
// - No bus response while running from battery.
// - Power-up reset time is 50, 200, 400 or 800 ms.
// - Watchdog interval is 25 ms, 200 ms, 1.4 s, or off.
// - Secondary-fail follows its comparator with no power-up delay.
// - Early low-supply output is driven low while primary is below threshold.
module cpusup_top #(
   parameter int TICK_CYCLES = `CPUSUP_TICK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic primary_ok_in,
   input wire logic secondary_monitor_in,
   input wire logic supply_above_batt_in,
   input wire logic supply_below_batt_in,
   input wire logic manual_reset_in_n,
   input wire logic write_protect_in,
   input wire logic sda_in,
   input wire logic scl_in,
   input wire logic cfg_wr_pulse,
   input wire logic [1:0] cfg_wd_sel,
   input wire logic [1:0] cfg_pup_sel,
   output logic sys_reset_out,
   output logic sys_reset_n_out,
   output logic watchdog_alarm_out_o,
   output logic watchdog_alarm_out_oe_n,
   output logic secondary_fail_out_o,
   output logic secondary_fail_out_oe_n,
   output logic early_low_supply_out_o,
   output logic early_low_supply_out_oe_n,
   output logic backup_active_out,
   output logic switched_supply_out,
   output logic bus_access_allow,
   output logic mem_write_allow,
   output logic timeout_select_hi,
   output logic timeout_select_lo,
   output logic [1:0] pup_select
);

   localparam logic [`CPUSUP_TICK_W-1:0] TICK_LAST = `CPUSUP_TICK_W'(TICK_CYCLES - 1);
   localparam logic [`CPUSUP_DEB_W-1:0] DEB_LAST =
      `CPUSUP_DEB_W'(`CPUSUP_MS_TICKS(`CPUSUP_DEB_MS) - 1);

   // ************************************************************
   // Input synchronisation
   // ************************************************************
   logic [`CPUSUP_IN_W-1:0] pins_raw;
   logic [`CPUSUP_IN_W-1:0] pins_s;
   wire pri_ok;
   wire sec_ok;
   wire above_batt;
   wire below_batt;
   wire mr_n_s;
   wire wp_s;

   // The synchroniser clears to zero, so levels whose safe state is high enter it
   // inverted; otherwise a false supply fail and button press would follow reset.
   assign pins_raw = {write_protect_in, !manual_reset_in_n, supply_below_batt_in,
                      supply_above_batt_in, !secondary_monitor_in, !primary_ok_in};

   cpusup_sync #(.W(`CPUSUP_IN_W)) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .en(ce),
      .d(pins_raw),
      .q(pins_s)
   );

   assign pri_ok = !pins_s[`CPUSUP_IN_PRI];
   assign sec_ok = !pins_s[`CPUSUP_IN_SEC];
   assign above_batt = pins_s[`CPUSUP_IN_ABOVE];
   assign below_batt = pins_s[`CPUSUP_IN_BELOW];
   assign mr_n_s = !pins_s[`CPUSUP_IN_MR];
   assign wp_s = pins_s[`CPUSUP_IN_WP];

   // ************************************************************
   // Slow tick
   // ************************************************************
   logic [`CPUSUP_TICK_W-1:0] tick_cnt_r;
   logic tick_r;

   // One divider serves every timeout so the long counters stay 12 bits wide.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= (tick_cnt_r == TICK_LAST);
         tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
      end
   end

   // ************************************************************
   // Manual reset debounce
   // ************************************************************
   logic mr_db_r;
   logic [`CPUSUP_DEB_W-1:0] deb_cnt_r;

   // The new level must hold for the whole debounce window; contact bounce
   // restarts the window, so a press shows as one clean assertion.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mr_db_r <= 1'b1;
         deb_cnt_r <= '0;
      end else if (ce) begin
         if (mr_n_s == mr_db_r) begin
            deb_cnt_r <= '0;
         end else if (tick_r) begin
            if (deb_cnt_r == DEB_LAST) begin
               mr_db_r <= mr_n_s;
               deb_cnt_r <= '0;
            end else begin
               deb_cnt_r <= deb_cnt_r + 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // Stored selections
   // ************************************************************
   logic [1:0] wd_sel_r;
   logic [1:0] pup_sel_r;
   wire cfg_take;

   assign cfg_take = cfg_wr_pulse && !wp_s && bus_access_allow;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wd_sel_r <= `CPUSUP_WD_SEL_RST;
         pup_sel_r <= `CPUSUP_PUP_SEL_RST;
      end else if (ce && cfg_take) begin
         wd_sel_r <= cfg_wd_sel;
         pup_sel_r <= cfg_pup_sel;
      end
   end

   assign timeout_select_hi = wd_sel_r[1];
   assign timeout_select_lo = wd_sel_r[0];
   assign pup_select = pup_sel_r;

   // ************************************************************
   // Reset sequencer
   // ************************************************************
   cpusup_pkg::cpusup_rst_state_t rst_state_r;
   cpusup_pkg::cpusup_rst_state_t rst_state_nxt;
   logic [`CPUSUP_CNT_W-1:0] por_cnt_r;
   logic [`CPUSUP_CNT_W-1:0] por_cnt_nxt;
   logic sys_reset_r;
   wire hold_cond;
   wire [`CPUSUP_CNT_W-1:0] pup_ticks;
   wire [`CPUSUP_CNT_W-1:0] pup_last;

   assign hold_cond = !pri_ok || !mr_db_r;
   assign pup_ticks =
      (pup_sel_r == `CPUSUP_SEL_0) ? `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_PUP0_MS)) :
      (pup_sel_r == `CPUSUP_SEL_1) ? `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_PUP1_MS)) :
      (pup_sel_r == `CPUSUP_SEL_2) ? `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_PUP2_MS)) :
      `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_PUP3_MS));
   assign pup_last = pup_ticks - `CPUSUP_CNT_W'(1);

   always_comb begin
      rst_state_nxt = rst_state_r;
      por_cnt_nxt = por_cnt_r;
      case (rst_state_r)
         cpusup_pkg::cpusup_rst_hold: begin
            por_cnt_nxt = '0;
            if (!hold_cond) begin
               rst_state_nxt = cpusup_pkg::cpusup_rst_count;
            end
         end
         cpusup_pkg::cpusup_rst_count: begin
            if (hold_cond) begin
               rst_state_nxt = cpusup_pkg::cpusup_rst_hold;
               por_cnt_nxt = '0;
            end else if (tick_r) begin
               if (por_cnt_r == pup_last) begin
                  rst_state_nxt = cpusup_pkg::cpusup_rst_run;
                  por_cnt_nxt = '0;
               end else begin
                  por_cnt_nxt = por_cnt_r + 1'b1;
               end
            end
         end
         cpusup_pkg::cpusup_rst_run: begin
            if (hold_cond) begin
               rst_state_nxt = cpusup_pkg::cpusup_rst_hold;
            end
         end
         default: begin
            rst_state_nxt = cpusup_pkg::cpusup_rst_hold;
            por_cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_state_r <= cpusup_pkg::cpusup_rst_hold;
         por_cnt_r <= '0;
         sys_reset_r <= 1'b1;
      end else if (ce) begin
         rst_state_r <= rst_state_nxt;
         por_cnt_r <= por_cnt_nxt;
         sys_reset_r <= (rst_state_nxt != cpusup_pkg::cpusup_rst_run);
      end
   end

   assign sys_reset_out = sys_reset_r;
   assign sys_reset_n_out = !sys_reset_r;

   // ************************************************************
   // Watchdog
   // ************************************************************
   logic restart_tgl;
   logic restart_s;
   logic restart_d_r;
   logic [`CPUSUP_CNT_W-1:0] wd_cnt_r;
   logic wd_alarm_r;
   wire restart_p;
   wire wd_off;
   wire [`CPUSUP_CNT_W-1:0] wd_last;

   cpusup_bus_watch u_bus_watch (
      .link_clk(link_clk),
      .rst_n(rst_n),
      .ce(ce),
      .sda_in(sda_in),
      .scl_in(scl_in),
      .restart_tgl(restart_tgl)
   );

   cpusup_sync #(.W(1)) u_restart_sync (
      .clk(clk),
      .rst_n(rst_n),
      .en(ce),
      .d(restart_tgl),
      .q(restart_s)
   );

   assign restart_p = restart_s ^ restart_d_r;
   assign wd_off = (wd_sel_r == `CPUSUP_WD_OFF);
   assign wd_last =
      (wd_sel_r == `CPUSUP_SEL_0) ? `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_WD0_MS) - 1) :
      (wd_sel_r == `CPUSUP_SEL_1) ? `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_WD1_MS) - 1) :
      `CPUSUP_CNT_W'(`CPUSUP_MS_TICKS(`CPUSUP_WD2_MS) - 1);

   // The watchdog is held clear while the system is in reset, so a processor
   // that is still booting never sees a stale alarm.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         restart_d_r <= 1'b0;
         wd_cnt_r <= '0;
         wd_alarm_r <= 1'b0;
      end else if (ce) begin
         restart_d_r <= restart_s;
         if (restart_p || wd_off || sys_reset_r) begin
            wd_cnt_r <= '0;
            wd_alarm_r <= 1'b0;
         end else if (tick_r && !wd_alarm_r) begin
            if (wd_cnt_r == wd_last) begin
               wd_alarm_r <= 1'b1;
               wd_cnt_r <= '0;
            end else begin
               wd_cnt_r <= wd_cnt_r + 1'b1;
            end
         end
      end
   end

   assign watchdog_alarm_out_o = 1'b0;
   assign watchdog_alarm_out_oe_n = !wd_alarm_r;

   // ************************************************************
   // Supply flags and battery switch
   // ************************************************************
   logic sec_fail_r;
   logic low_supply_r;
   logic on_batt_r;
   wire on_batt_nxt;

   // Hysteresis: leave the battery when the primary is good or above the upper window edge, and go
   // to it only below the lower one, so a supply near the battery cannot chatter.
   assign on_batt_nxt = pri_ok ? 1'b0 : (on_batt_r ? !above_batt : below_batt);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sec_fail_r <= 1'b0;
         low_supply_r <= 1'b0;
         on_batt_r <= 1'b0;
      end else if (ce) begin
         sec_fail_r <= !sec_ok;
         low_supply_r <= !pri_ok;
         on_batt_r <= on_batt_nxt;
      end
   end

   assign secondary_fail_out_o = 1'b0;
   assign secondary_fail_out_oe_n = !sec_fail_r;
   assign early_low_supply_out_o = 1'b0;
   assign early_low_supply_out_oe_n = !low_supply_r;
   assign backup_active_out = on_batt_r;
   assign switched_supply_out = on_batt_r;
   assign bus_access_allow = !sys_reset_r && !on_batt_r;
   assign mem_write_allow = bus_access_allow && !wp_s;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [`CPUSUP_CNT_W-1:0] rel_ticks_r;

   always_ff @(posedge clk) begin
      if (!rst_n || (ce && (hold_cond || rst_state_r != cpusup_pkg::cpusup_rst_count))) begin
         rel_ticks_r <= '0;
      end else if (ce && tick_r) begin
         rel_ticks_r <= rel_ticks_r + 1'b1;
      end
   end

   release_time_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(sys_reset_r) |-> (rel_ticks_r == pup_ticks)
   ) else $error("reset released before the power-up time elapsed");

   supply_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && !pri_ok) |=> sys_reset_r
   ) else $error("reset not asserted for a low primary supply");

   manual_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && !mr_db_r) |=> (sys_reset_r && rst_state_r == cpusup_pkg::cpusup_rst_hold)
   ) else $error("reset not held during manual reset");

   wd_expire_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(wd_alarm_r) |-> ($past(wd_cnt_r) == wd_last && $past(tick_r) && !$past(wd_off))
   ) else $error("watchdog alarm at the wrong count");

   wd_restart_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && restart_p) |=> (!wd_alarm_r && wd_cnt_r == '0) ##1
         (!wd_alarm_r && wd_cnt_r <= `CPUSUP_CNT_W'(1))
   ) else $error("bus restart did not clear the watchdog");

   sec_follow_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && $past(ce)) |-> (secondary_fail_out_oe_n == $past(sec_ok))
   ) else $error("secondary fail output does not follow its comparator");

   low_follow_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && pri_ok != $past(pri_ok)) |=> (early_low_supply_out_oe_n == $past(pri_ok))
   ) else $error("early low supply output wrong");

   batt_switch_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && pri_ok) |=> (!backup_active_out && !switched_supply_out)
   ) else $error("battery selected while primary supply is good");

   bus_gate_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (on_batt_r || sys_reset_r) |-> (!bus_access_allow && !mem_write_allow)
   ) else $error("bus access allowed during reset or backup");

   wp_refuse_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ce && cfg_wr_pulse && wp_s) |=> ($stable(wd_sel_r) && $stable(pup_sel_r))
   ) else $error("write accepted while write protect is high");

endmodule

// [verification/cpusup_host_model.sv]
/*
 Host side of the two-wire bus: sends one frame per request, a watchdog restart frame only when full is high.
 Assumes go is held by the requester until done rises; SDA and SCL have pull-ups.
*/
`timescale 1ns/1ps
module cpusup_host_model (
   input wire logic link_clk,
   input wire logic go,
   input wire logic full,
   output logic sda,
   output logic scl,
   output logic done
);
   // The clock stands high between frames, as a released line with a pull-up would.
   initial begin
      sda = 1'b1;
      scl = 1'b1;
      done = 1'b0;
      forever begin
         @(posedge link_clk);
         if (go && !done) begin
            sda <= 1'b0;
            @(posedge link_clk);
            if (full) begin
               scl <= 1'b0;
               @(posedge link_clk);
               scl <= 1'b1;
               @(posedge link_clk);
            end
            sda <= 1'b1;
            @(posedge link_clk);
            done <= 1'b1;
         end else if (!go) begin
            done <= 1'b0;
         end
      end
   end
endmodule

// [verification/tb_cpusup_top.sv]
/*
 Self-checking bench of the supervisor with a 10-cycle slow tick.
 Assumes the host model drives the bus lines on an unrelated 80 ns clock.
*/
`timescale 1ns/1ps
module tb_cpusup_top;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pri = 1'b1, sec = 1'b1, above = 1'b1, below = 1'b0, mr_n = 1'b1, wp = 1'b0;
   logic wr = 1'b0, go = 1'b0, full = 1'b1;
   logic [1:0] wd = 2'h0, pup = 2'h0;
   logic sda, scl, done, rst_o, al_n, sf_n, el_n, bk, sw, bus_ok, wr_ok, hi, lo;
   logic rst_no, al_o, sf_o, el_o;
   logic [1:0] pup_q;
   int n_errors = 0, total_checks = 0, cyc = 0, k;

   always #4 clk = ~clk;
   initial #3 forever #40 link_clk = ~link_clk;

   cpusup_top #(.TICK_CYCLES(10)) cpusup_top_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .link_clk(link_clk), .primary_ok_in(pri), .secondary_monitor_in(sec),
      .supply_above_batt_in(above), .supply_below_batt_in(below), .manual_reset_in_n(mr_n),
      .write_protect_in(wp), .sda_in(sda), .scl_in(scl), .cfg_wr_pulse(wr),
      .cfg_wd_sel(wd), .cfg_pup_sel(pup), .sys_reset_out(rst_o), .sys_reset_n_out(rst_no),
      .watchdog_alarm_out_o(al_o), .watchdog_alarm_out_oe_n(al_n), .secondary_fail_out_o(sf_o),
      .secondary_fail_out_oe_n(sf_n), .early_low_supply_out_o(el_o),
      .early_low_supply_out_oe_n(el_n), .backup_active_out(bk), .switched_supply_out(sw),
      .bus_access_allow(bus_ok), .mem_write_allow(wr_ok), .timeout_select_hi(hi),
      .timeout_select_lo(lo), .pup_select(pup_q));
   cpusup_host_model cpusup_host_model_i (.link_clk(link_clk), .go(go), .full(full),
      .sda(sda), .scl(scl), .done(done));

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic endt(input int t);
      $display("test %0d done", t);
   endtask
   task automatic cfgw(input logic [1:0] w, input logic [1:0] p);
      wd = w;
      pup = p;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(2);
   endtask
   task automatic frame(input logic f);
      int i;
      full = f;
      go = 1'b1;
      for (i = 0; i < 200 && done !== 1'b1; i++) step(1);
      chk(done, 1'b1);
      go = 1'b0;
      step(40);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Ceiling well above the sum of the waits below.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         finish_test;
      end
   end

   initial begin
      step(20);
      chk({rst_o, bus_ok}, 2'h2);
      chk({al_n, bk}, 2'h2);
      chk({rst_o, rst_no}, 2'h2);
      rst_n = 1'b1;
      step(450);
      chk(rst_o, 1'b1);
      for (k = 0; k < 300 && rst_o !== 1'b0; k++) step(1);
      chk({rst_o, bus_ok}, 2'h1);
      chk({rst_o, rst_no}, 2'h1);
      endt(1);
      step(220);
      chk(al_n, 1'b1);
      step(70);
      chk(al_n, 1'b0);
      frame(1'b0);
      chk(al_n, 1'b0);
      frame(1'b1);
      chk(al_n, 1'b1);
      endt(2);
      wp = 1'b1;
      step(5);
      chk(wr_ok, 1'b0);
      cfgw(2'h3, 2'h3);
      chk({hi, lo}, 2'h0);
      wp = 1'b0;
      step(5);
      chk(wr_ok, 1'b1);
      step(300);
      chk(al_n, 1'b0);
      for (k = 0; k < 4; k++) begin
         cfgw(k[1:0], k[1:0]);
         chk({hi, lo}, k[1:0]);
         chk(pup_q, k[1:0]);
      end
      step(400);
      chk(al_n, 1'b1);
      endt(3);
      sec = 1'b0;
      step(5);
      chk(sf_n, 1'b0);
      chk({al_o, sf_o}, 2'h0);
      sec = 1'b1;
      step(5);
      chk({sf_n, rst_o}, 2'h2);
      endt(4);
      mr_n = 1'b0;
      step(100);
      chk(rst_o, 1'b1);
      mr_n = 1'b1;
      step(7500);
      chk(rst_o, 1'b1);
      step(900);
      chk(rst_o, 1'b0);
      endt(5);
      pri = 1'b0;
      step(5);
      chk({rst_o, el_n}, 2'h2);
      chk(el_o, 1'b0);
      above = 1'b0;
      below = 1'b1;
      step(5);
      chk({bk, sw}, 2'h3);
      chk(bus_ok, 1'b0);
      cfgw(2'h0, 2'h0);
      chk(pup_q, 2'h3);
      below = 1'b0;
      step(5);
      chk({bk, sw}, 2'h3);
      above = 1'b1;
      step(5);
      chk({bk, sw}, 2'h0);
      pri = 1'b1;
      step(5);
      chk(el_n, 1'b1);
      endt(6);
      finish_test;
   end
endmodule
